// *** wdt_core.sv ***
// Watchdog timer with reset, APB register slave.
// Assumes low-power mode, power-on reset and mode straps come from the
// system controller; the oscillator tick is derived from pclk.
`timescale 1ns/1ps
`default_nettype none
module wdt_core
  import wdt_pkg::*;
#(
  parameter int OSC_DIV = OSC_DIV_DEFAULT
) (
  input wire logic pclk, // APB clock, 100 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic por_n, // Power-on reset, active low
  input wire logic [11:0] paddr, // APB byte address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic wd_irq, // Interrupt request
  output logic wd_wakeup, // Wake pulse at timeout in low power
  output logic wd_sys_reset // System reset request
);

  // ==========================================================
  // Functions
  function automatic logic [7:0] ps_mask(input logic [2:0] sel);
    case (sel)
      3'd0: ps_mask = 8'h00;
      3'd1: ps_mask = 8'h03;
      3'd2: ps_mask = 8'h07;
      3'd3: ps_mask = 8'h0f;
      3'd4: ps_mask = 8'h1f;
      3'd5: ps_mask = 8'h3f;
      3'd6: ps_mask = 8'h7f;
      default: ps_mask = 8'hff;
    endcase
  endfunction : ps_mask

  // ==========================================================
  // State
  // One-hot key sequencer: idle, first key seen, protected write open
  typedef enum logic [2:0] {
    WDT_KEY_IDLE = 3'b001,
    WDT_KEY_HALF = 3'b010,
    WDT_KEY_OPEN = 3'b100
  } wdt_key_e;

  wdt_ctrl_s ctrl_view;
  logic run_reg;
  logic clr_pend_reg;
  logic tof_reg;
  logic lpr_reg;
  logic rflag_reg;
  logic [2:0] ps_reg;
  logic [3:0] mode_reg;
  logic wdie_reg;
  logic gie_reg;
  logic idle_reg;
  logic pdwn_reg;
  logic lp_prev_reg;
  wdt_key_e key_state_reg;
  logic [2:0] key_win_reg;
  logic [15:0] osc_cnt_reg;
  logic osc_tick;
  logic [7:0] pre_reg;
  logic [5:0] wd_cnt_reg;
  logic [9:0] grace_reg;
  wdt_state_e state_reg;
  logic sys_rst_prev_reg;

  logic acc;
  logic wr;
  logic rd_ok;
  logic unlocked;
  logic ctrl_wr;
  logic gp_mode;
  logic low_power;
  logic lp_edge;
  logic running;
  logic pre_done;
  logic overflow;
  logic clr_req;
  logic key_wr;
  logic [7:0] key_byte;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign pready = 1'b1;
  assign rd_ok = (paddr == WDT_CTRL_ADDR) || (paddr == WDT_KEY_ADDR)
    || (paddr == WDT_SYS_ADDR);
  assign pslverr = acc && !rd_ok;
  assign unlocked = (key_state_reg == WDT_KEY_OPEN);
  assign ctrl_wr = wr && (paddr == WDT_CTRL_ADDR) && unlocked;
  assign gp_mode = (mode_reg == MODE_GP);
  assign low_power = idle_reg || pdwn_reg;
  assign lp_edge = low_power != lp_prev_reg;
  assign clr_req = ctrl_wr && pwdata[BIT_CLR];
  assign key_wr = wr && (paddr == WDT_KEY_ADDR);
  assign key_byte = pwdata[7:0];

  // ==========================================================
  // Timed access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_state_reg <= WDT_KEY_IDLE;
      key_win_reg <= 3'd0;
    end else begin
      case (key_state_reg)
        WDT_KEY_IDLE: begin
          if (key_wr && key_byte == KEY_FIRST) begin
            key_state_reg <= WDT_KEY_HALF;
          end
        end
        WDT_KEY_HALF: begin
          // Any other write between the two keys aborts the sequence
          if (key_wr && key_byte == KEY_SECOND) begin
            key_state_reg <= WDT_KEY_OPEN;
            key_win_reg <= 3'(KEY_WINDOW);
          end else if (wr) begin
            key_state_reg <= WDT_KEY_IDLE;
          end
        end
        WDT_KEY_OPEN: begin
          // One protected write only, and only shortly after the key
          if (wr || key_win_reg == 3'd0) begin
            key_state_reg <= WDT_KEY_IDLE;
          end else begin
            key_win_reg <= key_win_reg - 3'd1;
          end
        end
        default: begin
          key_state_reg <= WDT_KEY_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // System control (mode strap, enables, power state)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= MODE_GP;
      wdie_reg <= 1'b0;
      gie_reg <= 1'b0;
      idle_reg <= 1'b0;
      pdwn_reg <= 1'b0;
    end else if (wr && paddr == WDT_SYS_ADDR) begin
      mode_reg <= pwdata[SYS_MODE_LO +: 4];
      wdie_reg <= pwdata[SYS_WDIE];
      gie_reg <= pwdata[SYS_GIE];
      idle_reg <= pwdata[SYS_IDLE];
      pdwn_reg <= pwdata[SYS_PDWN];
    end else if (overflow && low_power) begin
      idle_reg <= 1'b0;
      pdwn_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_prev_reg <= 1'b0;
    end else begin
      lp_prev_reg <= low_power;
    end
  end

  // ==========================================================
  // Oscillator tick from pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt_reg <= 16'h0000;
    end else if (osc_cnt_reg == 16'(OSC_DIV - 1)) begin
      osc_cnt_reg <= 16'h0000;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 16'h0001;
    end
  end
  assign osc_tick = (osc_cnt_reg == 16'(OSC_DIV - 1));

  // ==========================================================
  // Counter and prescaler
  always_comb begin
    if (gp_mode) begin
      running = run_reg && (!low_power || lpr_reg);
    end else begin
      running = !(low_power && mode_reg == MODE_STOP_LP);
    end
  end
  assign pre_done = (pre_reg & ps_mask(ps_reg)) == ps_mask(ps_reg);
  assign overflow = running && osc_tick && pre_done
    && (wd_cnt_reg == 6'(TICKS_PER_TIMEOUT - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= 8'h00;
      wd_cnt_reg <= 6'h00;
    end else if (lp_edge || clr_req) begin
      pre_reg <= 8'h00;
      wd_cnt_reg <= 6'h00;
    end else if (running && osc_tick) begin
      pre_reg <= pre_done ? 8'h00 : pre_reg + 8'h01;
      if (pre_done) begin
        wd_cnt_reg <= wd_cnt_reg + 6'h01;
      end
    end
  end

  // ==========================================================
  // Grace period and reset sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= WDT_ST_COUNT;
      grace_reg <= 10'h000;
    end else begin
      case (state_reg)
        WDT_ST_COUNT: begin
          if (overflow && !gp_mode) begin
            state_reg <= WDT_ST_GRACE;
            grace_reg <= 10'h000;
          end
        end
        WDT_ST_GRACE: begin
          if (clr_req) begin
            state_reg <= WDT_ST_COUNT;
          end else if (osc_tick) begin
            if (grace_reg == 10'(GRACE_TICKS - 1)) begin
              state_reg <= WDT_ST_RESET;
            end else begin
              grace_reg <= grace_reg + 10'h001;
            end
          end
        end
        WDT_ST_RESET: begin
          state_reg <= WDT_ST_RESET;
        end
        default: begin
          state_reg <= WDT_ST_COUNT;
        end
      endcase
    end
  end
  assign wd_sys_reset = (state_reg == WDT_ST_RESET);

  // ==========================================================
  // Control register
  // Reset flag and prescale survive presetn; only por_n touches them.
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      sys_rst_prev_reg <= 1'b0;
    end else begin
      sys_rst_prev_reg <= wd_sys_reset;
    end
  end

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      rflag_reg <= 1'b0;
    end else if (wd_sys_reset && !sys_rst_prev_reg) begin
      rflag_reg <= 1'b1;
    end else if (ctrl_wr) begin
      rflag_reg <= pwdata[BIT_RSTF];
    end
  end

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      ps_reg <= PS_RESET;
    end else if (ctrl_wr) begin
      ps_reg <= pwdata[PS_HI:0];
    end
  end

  // Clear lands in the counter next edge, so pending lasts one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_pend_reg <= 1'b0;
    end else begin
      clr_pend_reg <= clr_req;
    end
  end

  // Hardware set wins over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tof_reg <= 1'b0;
    end else if (overflow) begin
      tof_reg <= 1'b1;
    end else if (ctrl_wr) begin
      tof_reg <= pwdata[BIT_TOF];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= 1'b0;
      lpr_reg <= 1'b0;
    end else if (ctrl_wr) begin
      run_reg <= pwdata[BIT_RUN];
      lpr_reg <= pwdata[BIT_LPR];
    end
  end

  // ==========================================================
  // Register view
  always_comb begin
    ctrl_view.wd_run = run_reg;
    ctrl_view.count_clear = clr_pend_reg;
    ctrl_view.timeout_flag = tof_reg;
    ctrl_view.run_in_low_power = lpr_reg;
    ctrl_view.wd_reset_flag = rflag_reg;
    ctrl_view.prescale_select = ps_reg;
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_irq <= 1'b0;
    end else begin
      wd_irq <= tof_reg && wdie_reg && gie_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_wakeup <= 1'b0;
    end else begin
      wd_wakeup <= overflow && low_power;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        WDT_CTRL_ADDR: prdata <= {24'h00_0000, ctrl_view};
        WDT_KEY_ADDR: prdata <= {29'h0000_0000, key_state_reg};
        WDT_SYS_ADDR: prdata <= {24'h00_0000, mode_reg, pdwn_reg, idle_reg,
          gie_reg, wdie_reg};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : wdt_core
`default_nettype wire

// *** wdt_pkg.sv ***
// Watchdog timer package: register map, field layout, constants.
// Assumes an APB slave with 32-bit data; one control register per word.
package wdt_pkg;

  // ==========================================================
  // Register map
  localparam logic [11:0] WDT_CTRL_ADDR = 12'h0aa * 12'h004;
  localparam logic [11:0] WDT_KEY_ADDR = 12'h2c0;
  localparam logic [11:0] WDT_SYS_ADDR = 12'h2c4;

  // ==========================================================
  // Field positions of watchdog_control
  localparam int BIT_RUN = 7;
  localparam int BIT_CLR = 6;
  localparam int BIT_TOF = 5;
  localparam int BIT_LPR = 4;
  localparam int BIT_RSTF = 3;
  localparam int PS_HI = 2;

  // System control register fields (own)
  localparam int SYS_WDIE = 0;
  localparam int SYS_GIE = 1;
  localparam int SYS_IDLE = 2;
  localparam int SYS_PDWN = 3;
  localparam int SYS_MODE_LO = 4;

  // ==========================================================
  // Constants
  localparam logic [3:0] MODE_GP = 4'hf;
  localparam logic [3:0] MODE_STOP_LP = 4'h5;
  localparam logic [2:0] PS_RESET = 3'h7;
  localparam logic [7:0] KEY_FIRST = 8'haa;
  localparam logic [7:0] KEY_SECOND = 8'h55;
  localparam int KEY_WINDOW = 4;
  localparam int TICKS_PER_TIMEOUT = 64;
  localparam int GRACE_TICKS = 512;
  localparam int PCLK_HZ = 100_000_000;
  localparam int OSC_HZ = 10_000;
  localparam int OSC_DIV_DEFAULT = PCLK_HZ / OSC_HZ;

  typedef struct packed {
    logic wd_run;
    logic count_clear;
    logic timeout_flag;
    logic run_in_low_power;
    logic wd_reset_flag;
    logic [2:0] prescale_select;
  } wdt_ctrl_s;

  typedef enum logic [2:0] {
    WDT_ST_COUNT = 3'b001,
    WDT_ST_GRACE = 3'b010,
    WDT_ST_RESET = 3'b100
  } wdt_state_e;

endpackage : wdt_pkg

// *** wdt_core_asserts.sv ***
// Port-level checker for the watchdog block.
// Assumes it is bound onto wdt_core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module wdt_core_asserts
  import wdt_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic [11:0] paddr, // Address
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic wd_irq, // Interrupt
  input wire logic wd_wakeup, // Wake pulse
  input wire logic wd_sys_reset // Reset request
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic have_rd;
  logic [7:0] last_rd;
  wire logic acc = psel && penable;
  wire logic rd_ctrl = acc && !pwrite && paddr == WDT_CTRL_ADDR;
  wire logic mapped = paddr inside {WDT_CTRL_ADDR, WDT_KEY_ADDR, WDT_SYS_ADDR};
  // ======
  // Last control read; any write voids it, since software may change bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      have_rd <= 1'b0;
      last_rd <= 8'h00;
    end else if (acc && pwrite) begin
      have_rd <= 1'b0;
    end else if (rd_ctrl) begin
      have_rd <= 1'b1;
      last_rd <= prdata[7:0];
    end
  end
  // ======
  // Checks
  pready_high_a: assert property (pready) else $error("pready low");
  err_phase_a: assert property (pslverr |-> acc) else $error("stray pslverr");
  err_unmapped_a: assert property (acc && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  flag_sticky_a: assert property (rd_ctrl && have_rd && last_rd[BIT_TOF] |-> prdata[BIT_TOF])
    else $error("timeout flag dropped");
  ps_kept_a: assert property (rd_ctrl && have_rd |-> prdata[2:0] == last_rd[2:0])
    else $error("prescale changed");
  rflag_kept_a: assert property (rd_ctrl && have_rd && last_rd[BIT_RSTF] |-> prdata[BIT_RSTF])
    else $error("reset flag dropped");
  rdata_width_a: assert property (rd_ctrl |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  sysrst_hold_a: assert property (wd_sys_reset |=> wd_sys_reset)
    else $error("system reset released");
  wake_pulse_a: assert property (wd_wakeup |=> !wd_wakeup)
    else $error("wake pulse too long");
  cover property (wd_sys_reset);
  cover property (wd_irq);
  cover property (wd_wakeup);
endmodule : wdt_core_asserts
bind wdt_core wdt_core_asserts chk_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
  .prdata, .pready, .pslverr, .wd_irq, .wd_wakeup, .wd_sys_reset);
`default_nettype wire

// *** wdt_core_bench.sv ***
// Self-checking bench for wdt_core with an integer model.
// Assumes OSC_DIV of 2 pclk cycles per oscillator tick.
`timescale 1ns/1ps
`default_nettype none
module wdt_core_bench
  import wdt_pkg::*;
;
  localparam int DIV = 2;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  logic pclk = 1'b0, presetn = 1'b0, por_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, wd_irq, wd_wakeup, wd_sys_reset, er, woke = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = ZERO, prdata, rd, seed = 32'h0000_0006;
  int failures = 0, total_checks = 0, cyc = 0, t0, i, m_ps = 7, m_rf = 0;
  wdt_core #(.OSC_DIV(DIV)) dut_u (.pclk, .presetn, .por_n, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .wd_irq, .wd_wakeup, .wd_sys_reset);
  always #5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  always @(posedge pclk) if (wd_wakeup === 1'b1) woke <= 1'b1;
  // ======
  // Tasks
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic int per(int ps);
    return 64 * (ps == 0 ? 1 : 2 << ps) * DIV;
  endfunction : per
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s exp %h got %h", what, e, g);
    end
  endtask : chk
  task automatic chkb(input string what, input logic e, input logic g);
    chk(what, {31'h0000_0000, e}, {31'h0000_0000, g});
  endtask : chkb
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic kw(input logic [7:0] d);
    apb(WDT_KEY_ADDR, 1'b1, {24'h00_0000, KEY_FIRST});
    apb(WDT_KEY_ADDR, 1'b1, {24'h00_0000, KEY_SECOND});
    apb(WDT_CTRL_ADDR, 1'b1, {24'h00_0000, d});
  endtask : kw
  // Polls the flag; early slack covers an unaligned prescaler phase
  task automatic wflag(input int e, input int early);
    int n = 0;
    do begin
      apb(WDT_CTRL_ADDR, 1'b0, ZERO);
      n++;
    end while (rd[BIT_TOF] !== 1'b1 && n < 12000);
    chkb("interval", 1'b1, cyc - t0 <= e + 12 && cyc - t0 >= e - early);
  endtask : wflag
  task automatic rst(input logic por);
    @(posedge pclk);
    presetn <= 1'b0;
    por_n <= ~por;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
  endtask : rst
  task automatic rdctl();
    apb(WDT_CTRL_ADDR, 1'b0, ZERO);
    chk("ctrl", 32'(m_rf * 8 + m_ps), rd);
  endtask : rdctl
  task automatic finish_test();
    if (failures == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  // ======
  // Scenarios
  initial begin
    rst(1'b1);
    rdctl();
    apb(WDT_CTRL_ADDR, 1'b1, xs());
    rdctl();
    rd = xs();
    apb({2'b01, rd[7:0], 2'b00}, 1'b0, ZERO);
    chkb("slverr", 1'b1, er);
    for (i = 0; i < 8; i++) begin
      kw(8'hc0 | i[7:0]);
      t0 = cyc;
      wflag(per(i), per(i) / 64 + 6);
    end
    chkb("clear", 1'b0, rd[BIT_CLR]);
    kw(8'hc0);
    t0 = cyc;
    wflag(per(0), 8);
    kw(8'h80);
    wflag(2 * per(0), 8);
    apb(WDT_SYS_ADDR, 1'b1, 32'h0000_00f3);
    repeat (2) @(posedge pclk);
    chkb("irq", 1'b1, wd_irq);
    kw(8'h40);
    repeat (300) @(posedge pclk);
    chkb("irq", 1'b0, wd_irq);
    apb(WDT_CTRL_ADDR, 1'b0, ZERO);
    chkb("halt", 1'b0, rd[BIT_TOF]);
    kw(8'h80);
    apb(WDT_SYS_ADDR, 1'b1, 32'h0000_00f7);
    repeat (300) @(posedge pclk);
    apb(WDT_CTRL_ADDR, 1'b0, ZERO);
    chkb("idle", 1'b0, rd[BIT_TOF]);
    kw(8'h90);
    t0 = cyc;
    wflag(per(0), 8);
    chkb("wake", 1'b1, woke);
    kw(8'h40);
    apb(WDT_SYS_ADDR, 1'b1, 32'h0000_0003);
    t0 = cyc;
    wflag(per(0), 8);
    chkb("irq", 1'b1, wd_irq);
    apb(WDT_CTRL_ADDR, 1'b0, ZERO);
    chkb("sticky", 1'b1, rd[BIT_TOF]);
    repeat (400) @(posedge pclk);
    kw(8'h40);
    chkb("sysrst", 1'b0, wd_sys_reset);
    t0 = cyc;
    wflag(per(0), 8);
    t0 = cyc;
    i = 0;
    while (wd_sys_reset !== 1'b1 && i < 3000) begin
      @(posedge pclk);
      i++;
    end
    chkb("grace", 1'b1, cyc - t0 <= 512 * DIV + 6 && cyc - t0 >= 512 * DIV - 12);
    rst(1'b0);
    m_rf = 1;
    m_ps = 0;
    rdctl();
    rdctl();
    rst(1'b0);
    rdctl();
    rst(1'b1);
    m_rf = 0;
    m_ps = 7;
    rdctl();
    // Mode 5 halts in idle; any other reset mode keeps counting
    kw(8'h40);
    apb(WDT_SYS_ADDR, 1'b1, 32'h0000_0057);
    repeat (300) @(posedge pclk);
    apb(WDT_CTRL_ADDR, 1'b0, ZERO);
    chkb("stop5", 1'b0, rd[BIT_TOF]);
    apb(WDT_SYS_ADDR, 1'b1, 32'h0000_0037);
    t0 = cyc;
    wflag(per(0), 8);
    finish_test();
  end
  initial begin
    repeat (90000) @(posedge pclk);
    failures++;
    finish_test();
  end
endmodule : wdt_core_bench
`default_nettype wire
